// File: src/hpc_pkg.sv
// package of offsets, field positions, reset values and timing for the host port config block
// Notes on behaviour
// - upper nibble of the two-wire address is base field bits 7:4, lower nibble zero
// - address byte base/base+1 pages 0/1, base+2/+3 pages 2/3, base+5 reads 4/5
// - base field all zeros selects the hardware default interface address
// - bit 3 sets which read/write bit value means a read on four-wire
// - bit 2 selects the four-wire clock phase used for sampling and shifting
// - bit 1 sets the idle level of the four-wire serial clock
// - bit 0 sets chip-select polarity: 0 active low, 1 active high
// - bit 7 picks port type; four-wire forces two general pins into port use
// - bit 6 keeps the two-wire port in high-speed mode without master code
// - bit 5 selects fast-mode-plus timing on the two-wire port
// - with bit 4 set, clock low beyond 35 ms resets the two-wire port
// - interrupt output polarity follows bit 0: 0 active low, 1 active high
// - rail power-good hold bits keep the previous status during voltage changes
// - over-current code 00 active; others masked during change plus 2, 10, 50 us
// - rail B over-current code in bits 4:3, rail A in bits 2:1
// - bit 0 plus general input zero as input lets that pin trigger reload
// - bit 7 disables the I/O-rail undervoltage lockout and its comparator
// - with page auto return set, page select returns to 000 after an access, unless page control is written in the completing cycle
package hpc_pkg;
  localparam logic [8:0] OFS_PAGE_CTRL  = 9'h100;
  localparam logic [8:0] OFS_HOST_ADDR  = 9'h105;
  localparam logic [8:0] OFS_HOST_PORT  = 9'h106;
  localparam logic [8:0] OFS_IRQ_TO     = 9'h143;
  localparam logic [8:0] OFS_PROT_MASK  = 9'h144;

  localparam int BIT_RD_POL     = 3;
  localparam int BIT_CPHA       = 2;
  localparam int BIT_CPOL       = 1;
  localparam int BIT_SEL_POL    = 0;
  localparam int BIT_PORT_TYPE  = 7;
  localparam int BIT_HSM        = 6;
  localparam int BIT_FMP        = 5;
  localparam int BIT_TO_EN      = 4;
  localparam int BIT_IRQ_LEVEL  = 0;
  localparam int BIT_LOCKOUT_DIS = 7;
  localparam int BIT_PG_B_HOLD  = 6;
  localparam int BIT_PG_A_HOLD  = 5;
  localparam int BIT_OC_B_LO    = 3;
  localparam int BIT_OC_A_LO    = 1;
  localparam int BIT_RELOAD_EN  = 0;
  localparam int BIT_PAGE_RET   = 7;
  localparam logic [7:0] PAGE_CTRL_MASK = 8'hC7;
  localparam logic [7:0] HOST_PORT_MASK = 8'hF0;

  localparam logic [7:0] RST_HOST_ADDR = 8'h00;
  localparam logic [7:0] RST_HOST_PORT = 8'h80;
  localparam logic [7:0] RST_IRQ_TO    = 8'h00;
  localparam logic [7:0] RST_PROT_MASK = 8'h00;
  localparam logic [7:0] RST_PAGE_CTRL = 8'h00;
  localparam logic [2:0] PAGE_HOME     = 3'h0;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int STUCK_CLK_MS   = 35;
  localparam int STUCK_CLK_CYC  = (STUCK_CLK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int OC_EXTRA1_US   = 2;
  localparam int OC_EXTRA2_US   = 10;
  localparam int OC_EXTRA3_US   = 50;
  localparam int OC_CNT_W       = 11;
  localparam logic [OC_CNT_W-1:0] OC_EXTRA1_CYC = OC_CNT_W'((OC_EXTRA1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [OC_CNT_W-1:0] OC_EXTRA2_CYC = OC_CNT_W'((OC_EXTRA2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [OC_CNT_W-1:0] OC_EXTRA3_CYC = OC_CNT_W'((OC_EXTRA3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    HPC_GRP_P01 = 2'b00,
    HPC_GRP_P23 = 2'b01,
    HPC_GRP_P45 = 2'b10,
    HPC_GRP_NONE = 2'b11
  } hpc_grp_e;

  function automatic logic [OC_CNT_W-1:0] hpc_oc_extra(input logic [1:0] code);
    case (code)
      2'b01:   hpc_oc_extra = OC_EXTRA1_CYC;
      2'b10:   hpc_oc_extra = OC_EXTRA2_CYC;
      2'b11:   hpc_oc_extra = OC_EXTRA3_CYC;
      default: hpc_oc_extra = '0;
    endcase
  endfunction
endpackage

// File: src/hpc_oc_holdoff.sv
// over-current event hold-off for one buck rail around voltage changes
`timescale 1ns/1ps
module hpc_oc_holdoff
  import hpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] holdoff_code,
  input  wire logic       dynamic_voltage_change,
  input  wire logic       oc_hit,
  output logic            oc_event
);
  logic [OC_CNT_W-1:0] tail_cnt;
  logic                suppress;

  assign suppress = (holdoff_code != 2'b00) && (dynamic_voltage_change || tail_cnt != '0);

  // the tail restarts on every cycle of the change so it always counts from its end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tail_cnt <= '0;
    end else if (dynamic_voltage_change) begin
      tail_cnt <= hpc_oc_extra(holdoff_code);
    end else if (tail_cnt != '0) begin
      tail_cnt <= tail_cnt - OC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_event <= 1'b0;
    end else begin
      oc_event <= oc_hit && !suppress;
    end
  end

  property p_oc_masked_in_change;
    @(posedge clk) disable iff (!rst_n)
      (dynamic_voltage_change && holdoff_code != 2'b00) |=> !oc_event;
  endproperty
  a_oc_masked_in_change: assert property (p_oc_masked_in_change) else $error("over-current passed during change");

  property p_oc_code0_passes;
    @(posedge clk) disable iff (!rst_n)
      (holdoff_code == 2'b00 && oc_hit) |=> oc_event;
  endproperty
  a_oc_code0_passes: assert property (p_oc_code0_passes) else $error("over-current lost with code 00");
endmodule

// File: src/hpc_regs.sv
// host port and application configuration register bank
`timescale 1ns/1ps
module hpc_regs
  import hpc_pkg::*;
#(
  parameter int         STUCK_CYC    = STUCK_CLK_CYC,
  parameter logic [7:0] DEFAULT_ADDR = 8'hD0
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_rd_valid,
  input  wire logic       bus_busy,
  input  wire logic       access_done,
  input  wire logic       addr_byte_valid,
  input  wire logic [7:0] addr_byte,
  output logic            addr_hit,
  output logic            addr_is_read,
  output logic [1:0]      addr_page_group,
  output logic [7:0]      two_wire_base,
  input  wire logic       rw_bit,
  output logic            four_wire_is_read,
  input  wire logic       chip_select_n,
  output logic            four_wire_selected,
  output logic            clock_phase,
  output logic            clock_idle_high,
  output logic            four_wire_mode,
  output logic            general_pin_override,
  output logic            continuous_high_speed_en,
  output logic            fast_plus_timing_en,
  input  wire logic       serial_clock_pin,
  output logic            two_wire_port_reset,
  input  wire logic       irq_pending,
  output logic            interrupt_request_out,
  input  wire logic       dvc_a,
  input  wire logic       dvc_b,
  input  wire logic       pg_raw_a,
  input  wire logic       pg_raw_b,
  output logic            pg_a,
  output logic            pg_b,
  input  wire logic       oc_hit_a,
  input  wire logic       oc_hit_b,
  output logic            oc_event_a,
  output logic            oc_event_b,
  input  wire logic       general_input_zero,
  input  wire logic       general_input_zero_is_input,
  output logic            config_reload,
  input  wire logic       lockout_comp_raw,
  output logic            lockout_comp_en,
  output logic            undervoltage_lockout
);
  localparam int TO_W = $clog2(STUCK_CYC + 1);

  logic [7:0]      host_address_and_serial_format;
  logic [7:0]      host_port_selection;
  logic [7:0]      irq_and_timeout_config;
  logic [7:0]      protection_masking_config;
  logic [7:0]      page_ctrl;
  logic [TO_W-1:0] stuck_cnt;
  logic            general_input_zero_prev;
  logic [7:0]      next_base;
  logic [7:0]      next_rdata;

  // address byte decode against the live base
  function automatic logic [2:0] addr_decode(input logic [7:0] abyte, input logic [7:0] base);
    logic [2:0] res;
    res = {1'b0, HPC_GRP_NONE};
    if (abyte[7:4] == base[7:4]) begin
      if (abyte[3:0] == 4'h0 || abyte[3:0] == 4'h1) begin
        res = {1'b1, HPC_GRP_P01};
      end else if (abyte[3:0] == 4'h2 || abyte[3:0] == 4'h3) begin
        res = {1'b1, HPC_GRP_P23};
      end else if (abyte[3:0] == 4'h5) begin
        res = {1'b1, HPC_GRP_P45};
      end
    end
    addr_decode = res;
  endfunction

  // register writes; page auto return shares the page control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_address_and_serial_format <= RST_HOST_ADDR;
      host_port_selection            <= RST_HOST_PORT;
      irq_and_timeout_config         <= RST_IRQ_TO;
      protection_masking_config      <= RST_PROT_MASK;
    end else if (reg_wr_en) begin
      if (reg_addr == OFS_HOST_ADDR) begin
        host_address_and_serial_format <= reg_wdata;
      end else if (reg_addr == OFS_HOST_PORT) begin
        host_port_selection <= reg_wdata & HOST_PORT_MASK;
      end else if (reg_addr == OFS_IRQ_TO) begin
        irq_and_timeout_config <= reg_wdata;
      end else if (reg_addr == OFS_PROT_MASK) begin
        protection_masking_config <= reg_wdata;
      end
    end
  end

  // a write in the completing cycle wins so the new page is not lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_ctrl <= RST_PAGE_CTRL;
    end else if (reg_wr_en && reg_addr == OFS_PAGE_CTRL) begin
      page_ctrl <= reg_wdata & PAGE_CTRL_MASK;
    end else if (access_done && page_ctrl[BIT_PAGE_RET]) begin
      page_ctrl[2:0] <= PAGE_HOME;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == OFS_PAGE_CTRL) begin
      next_rdata = page_ctrl;
    end else if (reg_addr == OFS_HOST_ADDR) begin
      next_rdata = host_address_and_serial_format;
    end else if (reg_addr == OFS_HOST_PORT) begin
      next_rdata = host_port_selection;
    end else if (reg_addr == OFS_IRQ_TO) begin
      next_rdata = irq_and_timeout_config;
    end else if (reg_addr == OFS_PROT_MASK) begin
      next_rdata = protection_masking_config;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  always_comb begin
    if (host_address_and_serial_format[7:4] == 4'h0) begin
      next_base = DEFAULT_ADDR;
    end else begin
      next_base = {host_address_and_serial_format[7:4], 4'h0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      two_wire_base   <= DEFAULT_ADDR;
      addr_hit        <= 1'b0;
      addr_is_read    <= 1'b0;
      addr_page_group <= HPC_GRP_NONE;
    end else begin
      two_wire_base <= next_base;
      if (addr_byte_valid) begin
        {addr_hit, addr_page_group} <= addr_decode(addr_byte, next_base);
        addr_is_read                <= addr_byte[0];
      end else begin
        addr_hit <= 1'b0;
      end
    end
  end

  // format settings move only while the bus is idle; a mid-frame flip would garble the transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_phase          <= RST_HOST_ADDR[BIT_CPHA];
      clock_idle_high      <= RST_HOST_ADDR[BIT_CPOL];
      four_wire_mode       <= !RST_HOST_PORT[BIT_PORT_TYPE];
      general_pin_override <= !RST_HOST_PORT[BIT_PORT_TYPE];
    end else if (!bus_busy) begin
      clock_phase          <= host_address_and_serial_format[BIT_CPHA];
      clock_idle_high      <= host_address_and_serial_format[BIT_CPOL];
      four_wire_mode       <= !host_port_selection[BIT_PORT_TYPE];
      general_pin_override <= !host_port_selection[BIT_PORT_TYPE];
    end
  end

  // pin polarity is applied through a registered compare against the latched field, held during frames
  logic rd_pol_eff;
  logic sel_pol_eff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pol_eff  <= RST_HOST_ADDR[BIT_RD_POL];
      sel_pol_eff <= RST_HOST_ADDR[BIT_SEL_POL];
    end else if (!bus_busy) begin
      rd_pol_eff  <= host_address_and_serial_format[BIT_RD_POL];
      sel_pol_eff <= host_address_and_serial_format[BIT_SEL_POL];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      four_wire_is_read  <= 1'b0;
      four_wire_selected <= 1'b0;
    end else begin
      four_wire_is_read  <= (rw_bit == rd_pol_eff);
      four_wire_selected <= four_wire_mode && (chip_select_n == sel_pol_eff);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      continuous_high_speed_en <= 1'b0;
      fast_plus_timing_en      <= 1'b0;
    end else begin
      continuous_high_speed_en <= host_port_selection[BIT_HSM];
      fast_plus_timing_en      <= host_port_selection[BIT_FMP];
    end
  end

  // counter saturates so one stuck period gives a single reset pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stuck_cnt           <= '0;
      two_wire_port_reset <= 1'b0;
    end else begin
      two_wire_port_reset <= 1'b0;
      if (!irq_and_timeout_config[BIT_TO_EN] || serial_clock_pin || four_wire_mode) begin
        stuck_cnt <= '0;
      end else if (stuck_cnt != TO_W'(STUCK_CYC)) begin
        stuck_cnt <= stuck_cnt + TO_W'(1);
        if (stuck_cnt == TO_W'(STUCK_CYC - 1)) begin
          two_wire_port_reset <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_request_out <= 1'b1;
    end else begin
      interrupt_request_out <= irq_pending ^ !irq_and_timeout_config[BIT_IRQ_LEVEL];
    end
  end

  // with its hold bit set, power-good freezes at its last value for the whole change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_a <= 1'b0;
      pg_b <= 1'b0;
    end else begin
      if (!(dvc_a && protection_masking_config[BIT_PG_A_HOLD])) begin
        pg_a <= pg_raw_a;
      end
      if (!(dvc_b && protection_masking_config[BIT_PG_B_HOLD])) begin
        pg_b <= pg_raw_b;
      end
    end
  end

  hpc_oc_holdoff u_oc_a (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .holdoff_code           (protection_masking_config[BIT_OC_A_LO +: 2]),
    .dynamic_voltage_change (dvc_a),
    .oc_hit                 (oc_hit_a),
    .oc_event               (oc_event_a)
  );

  hpc_oc_holdoff u_oc_b (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .holdoff_code           (protection_masking_config[BIT_OC_B_LO +: 2]),
    .dynamic_voltage_change (dvc_b),
    .oc_hit                 (oc_hit_b),
    .oc_event               (oc_event_b)
  );

  // reload fires on the rising edge of the pin, once per edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_input_zero_prev     <= 1'b0;
      config_reload <= 1'b0;
    end else begin
      general_input_zero_prev     <= general_input_zero;
      config_reload <= protection_masking_config[BIT_RELOAD_EN] && general_input_zero_is_input
                       && general_input_zero && !general_input_zero_prev;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_comp_en      <= 1'b1;
      undervoltage_lockout <= 1'b0;
    end else begin
      lockout_comp_en      <= !protection_masking_config[BIT_LOCKOUT_DIS];
      undervoltage_lockout <= lockout_comp_raw && !protection_masking_config[BIT_LOCKOUT_DIS];
    end
  end

  property p_base_addr;
    @(posedge clk) disable iff (!rst_n)
      (host_address_and_serial_format[7:4] != 4'h0) |=> two_wire_base == {$past(host_address_and_serial_format[7:4]), 4'h0};
  endproperty
  a_base_addr: assert property (p_base_addr) else $error("base address not taken from field");

  property p_default_addr;
    @(posedge clk) disable iff (!rst_n)
      (host_address_and_serial_format[7:4] == 4'h0) |=> two_wire_base == DEFAULT_ADDR;
  endproperty
  a_default_addr: assert property (p_default_addr) else $error("default address not used");

  property p_addr_group;
    @(posedge clk) disable iff (!rst_n)
      (addr_byte_valid && addr_byte == (next_base | 8'h05)) |=> addr_hit && addr_page_group == HPC_GRP_P45;
  endproperty
  a_addr_group: assert property (p_addr_group) else $error("base+5 not decoded as pages 4/5");

  property p_fmt_frozen;
    @(posedge clk) disable iff (!rst_n)
      bus_busy |=> $stable(clock_phase) && $stable(clock_idle_high) && $stable(four_wire_mode);
  endproperty
  a_fmt_frozen: assert property (p_fmt_frozen) else $error("format changed during transaction");

  property p_stuck_reset;
    @(posedge clk) disable iff (!rst_n)
      two_wire_port_reset |-> $past(stuck_cnt) == TO_W'(STUCK_CYC - 1) && !$past(serial_clock_pin);
  endproperty
  a_stuck_reset: assert property (p_stuck_reset) else $error("port reset without full stuck period");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
      (irq_pending && irq_and_timeout_config[BIT_IRQ_LEVEL]) ##1 irq_and_timeout_config[BIT_IRQ_LEVEL] |-> interrupt_request_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("active-high interrupt not driven high");

  property p_pg_hold;
    @(posedge clk) disable iff (!rst_n)
      (dvc_a && protection_masking_config[BIT_PG_A_HOLD]) |=> $stable(pg_a);
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power-good moved during masked change");

  property p_page_return;
    @(posedge clk) disable iff (!rst_n)
      (access_done && page_ctrl[BIT_PAGE_RET] && !(reg_wr_en && reg_addr == OFS_PAGE_CTRL)) |=> page_ctrl[2:0] == PAGE_HOME;
  endproperty
  a_page_return: assert property (p_page_return) else $error("page not returned after access");

  property p_lockout_off;
    @(posedge clk) disable iff (!rst_n)
      protection_masking_config[BIT_LOCKOUT_DIS] ##1 protection_masking_config[BIT_LOCKOUT_DIS] |-> !undervoltage_lockout && !lockout_comp_en;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("lockout raised while disabled");
endmodule

// File: tb/hpc_host_model.sv
// host processor model issuing single-byte register accesses
`timescale 1ns/1ps
module hpc_host_model (
  input  wire logic clk,
  output logic       wr_en,
  output logic       rd_en,
  output logic [8:0] addr,
  output logic [7:0] wdata,
  output logic       busy,
  output logic       done
);
  logic keep = 1'b0;
  initial {wr_en, rd_en, addr, wdata, busy, done} = '0;
  // busy frames each access so format changes wait for the gap
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    {busy, wr_en, rd_en, addr, wdata} = {1'b1, w, !w, a, d};
    @(negedge clk);
    {wr_en, rd_en, done} = 3'b001;
    // released lines show no stale offset or data
    addr = ~a;
    wdata = ~d;
    @(negedge clk);
    done = 1'b0;
    busy = keep;
  endtask
  task automatic free();
    @(negedge clk);
    keep = 1'b0;
    busy = 1'b0;
  endtask
endmodule

// File: tb/test_hpc_regs.sv
// self-checking bench for the host port configuration register bank
`timescale 1ns/1ps
module test_hpc_regs;
  import hpc_pkg::*;
  localparam int STK = 20;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr_en, reg_rd_en, bus_busy, access_done, reg_rd_valid, addr_byte_valid, addr_hit;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, addr_byte, two_wire_base, v, b;
  logic [1:0] addr_page_group;
  logic       addr_is_read, rw_bit, four_wire_is_read, chip_select_n, four_wire_selected, clock_phase;
  logic       clock_idle_high, four_wire_mode, general_pin_override, continuous_high_speed_en;
  logic       fast_plus_timing_en, serial_clock_pin, two_wire_port_reset, irq_pending, pg_a, pg_b;
  logic       interrupt_request_out, dvc_a, dvc_b, pg_raw_a, pg_raw_b, oc_hit_a, oc_hit_b;
  logic       oc_event_a, oc_event_b, general_input_zero, general_input_zero_is_input, config_reload;
  logic       lockout_comp_raw, lockout_comp_en, undervoltage_lockout;
  int         err_count = 0, checks_done = 0, cyc = 0, n_prst = 0, n_rld = 0, ex;
  int         seed = 32'hb24b;
  logic [7:0] exp_q[$];

  hpc_host_model host (
    .clk   (clk),
    .wr_en (reg_wr_en),
    .rd_en (reg_rd_en),
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .busy  (bus_busy),
    .done  (access_done)
  );
  hpc_regs #(.STUCK_CYC(STK), .DEFAULT_ADDR(8'hA0)) DUT (.*);

  always #20 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // read results are matched against the oldest note, whatever the latency;
  // outputs are looked at on the falling edge, where they have settled
  always @(negedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      end_sim();
    end
    if (two_wire_port_reset === 1'b1) n_prst++;
    if (config_reload === 1'b1) n_rld++;
    if (reg_rd_valid === 1'b1) chk("rdata", exp_q.size() ? exp_q.pop_front() : 8'hXX, reg_rdata);
  end

  initial begin
    {addr_byte_valid, addr_byte, rw_bit, irq_pending, dvc_a, dvc_b, pg_raw_a, pg_raw_b} = '0;
    {oc_hit_a, oc_hit_b, general_input_zero, general_input_zero_is_input, lockout_comp_raw} = '0;
    chip_select_n = 1'b1;
    serial_clock_pin = 1'b1;
    step(2);
    rst_n = 1'b1;
    rd(OFS_HOST_ADDR, RST_HOST_ADDR);
    rd(OFS_HOST_PORT, RST_HOST_PORT);
    rd(OFS_IRQ_TO, RST_IRQ_TO);
    rd(OFS_PROT_MASK, RST_PROT_MASK);
    wr(9'h1FF, 8'hFF);
    rd(9'h1FF, 8'h00);
    chk("base", 8'hA0, two_wire_base);
    repeat (3) begin
      v = $random(seed);
      wr(OFS_HOST_PORT, v);
      rd(OFS_HOST_PORT, v & HOST_PORT_MASK);
      wr(OFS_PROT_MASK, ~v);
      rd(OFS_PROT_MASK, ~v);
      wr(OFS_IRQ_TO, v & 8'hEF);
      rd(OFS_IRQ_TO, v & 8'hEF);
    end
    b = {v[7:4] | 4'h1, 4'h0};
    wr(OFS_HOST_ADDR, b);
    step(2);
    chk("base", b, two_wire_base);
    for (int o = 0; o < 8; o++) begin
      addr_byte = b + 8'(o);
      addr_byte_valid = 1'b1;
      step(1);
      addr_byte_valid = 1'b0;
      chk("hit", 8'(o inside {0, 1, 2, 3, 5}), 8'(addr_hit));
      chk("group", o < 2 ? 8'h0 : o < 4 ? 8'h1 : o == 5 ? 8'h2 : 8'h3, 8'(addr_page_group));
      if (addr_hit === 1'b1) chk("is_read", 8'(o % 2), 8'(addr_is_read));
    end
    wr(OFS_HOST_PORT, 8'h00);
    for (int f = 0; f < 16; f++) begin
      v = {b[7:4], 4'(f)};
      wr(OFS_HOST_ADDR, v);
      rw_bit = 1'($random(seed));
      chip_select_n = 1'($random(seed));
      step(3);
      chk("is_read4", 8'(rw_bit == v[3]), 8'(four_wire_is_read));
      chk("phase", 8'(v[2]), 8'(clock_phase));
      chk("idle", 8'(v[1]), 8'(clock_idle_high));
      chk("select", 8'(chip_select_n == v[0]), 8'(four_wire_selected));
      chk("mode", 8'h3, 8'({four_wire_mode, general_pin_override}));
    end
    host.keep = 1'b1;
    wr(OFS_HOST_ADDR, v ^ 8'h06);
    step(3);
    chk("held", 8'(v[2:1]), 8'({clock_phase, clock_idle_high}));
    host.free();
    step(3);
    chk("applied", 8'({~v[2], ~v[1]}), 8'({clock_phase, clock_idle_high}));
    repeat (2) begin
      v = {1'b1, 7'($random(seed))};
      wr(OFS_HOST_PORT, v);
      step(3);
      chk("mode", 8'h0, 8'({four_wire_mode, general_pin_override}));
      chk("hs", 8'(v[6]), 8'(continuous_high_speed_en));
      chk("fmp", 8'(v[5]), 8'(fast_plus_timing_en));
    end
    wr(OFS_IRQ_TO, 8'h10);
    irq_pending = 1'b1;
    serial_clock_pin = 1'b0;
    step(STK + 10);
    chk("irq", 8'h0, 8'(interrupt_request_out));
    serial_clock_pin = 1'b1;
    step(1);
    serial_clock_pin = 1'b0;
    step(STK / 2);
    chk("port_reset", 8'h1, 8'(n_prst));
    wr(OFS_IRQ_TO, 8'h01);
    step(STK + 10);
    chk("port_reset", 8'h1, 8'(n_prst));
    chk("irq", 8'h1, 8'(interrupt_request_out));
    irq_pending = 1'b0;
    serial_clock_pin = 1'b1;
    step(3);
    chk("irq", 8'h0, 8'(interrupt_request_out));
    {pg_raw_a, pg_raw_b, lockout_comp_raw} = 3'b111;
    wr(OFS_PROT_MASK, 8'h60);
    step(2);
    chk("lockout", 8'h3, 8'({undervoltage_lockout, lockout_comp_en}));
    {dvc_a, dvc_b, pg_raw_a, pg_raw_b} = 4'b1100;
    step(3);
    chk("pg", 8'h3, 8'({pg_b, pg_a}));
    wr(OFS_PROT_MASK, 8'h80);
    step(2);
    chk("pg", 8'h0, 8'({pg_b, pg_a}));
    chk("lockout", 8'h0, 8'({undervoltage_lockout, lockout_comp_en}));
    wr(OFS_PROT_MASK, 8'h18);
    {oc_hit_a, oc_hit_b} = 2'b11;
    step(4);
    chk("oc", 8'h1, 8'({oc_event_b, oc_event_a}));
    for (int k = 0; k < 4; k++) begin
      ex = k == 1 ? int'(OC_EXTRA1_CYC) : k == 2 ? int'(OC_EXTRA2_CYC) : int'(OC_EXTRA3_CYC);
      wr(OFS_PROT_MASK, 8'(k * 10));
      {dvc_a, dvc_b} = 2'b11;
      step(4);
      chk("oc", k == 0 ? 8'h3 : 8'h0, 8'({oc_event_b, oc_event_a}));
      {dvc_a, dvc_b} = 2'b00;
      if (k > 0) step(ex - 3);
      if (k > 0) chk("oc_tail", 8'h0, 8'({oc_event_b, oc_event_a}));
      step(8);
      chk("oc", 8'h3, 8'({oc_event_b, oc_event_a}));
    end
    wr(OFS_PROT_MASK, 8'h01);
    general_input_zero_is_input = 1'b1;
    general_input_zero = 1'b1;
    step(3);
    {general_input_zero, general_input_zero_is_input} = 2'b00;
    step(2);
    general_input_zero = 1'b1;
    step(3);
    chk("reload", 8'h1, 8'(n_rld));
    wr(OFS_PAGE_CTRL, 8'h83);
    rd(OFS_PAGE_CTRL, 8'h80);
    wr(OFS_PAGE_CTRL, 8'h03);
    rd(OFS_PAGE_CTRL, 8'h03);
    step(4);
    chk("pending", 8'h0, 8'(exp_q.size()));
    end_sim();
  end
endmodule
